// >>> memory_sync_handshake_test.sv
`timescale 1ns/10ps
module memory_sync_handshake_test;
    logic clk = 0, srst = 1, iv = 0, irq = 0, sbe = 1, pop = 0, rqi = 0;
    logic slow = 0, s, stall, flush, done, abrt, drn, rqo, acki, acko;
    logic [1:0] kind = 2'h0;
    logic [4:0] ord = 5'h00;
    logic [3:0] cnt = 4'h0;
    int miscompares = 0, compares = 0, cyc = 0, seed = 60, i;
    always #10 clk = ~clk;
    msh_core msh_core_inst (.clk(clk), .srst(srst), .insn_valid(iv),
        .insn_kind(kind), .barrier_ordering_field(ord),
        .irq_pending(irq), .store_bufs_empty(sbe), .snoop_q_count(cnt),
        .snoop_pop(pop), .operand_stall(stall), .store_flush(flush),
        .sync_done(done), .sync_abort(abrt), .snoop_drain(drn),
        .sync_req_out(rqo), .sync_ack_in(acki), .sync_req_in(rqi),
        .sync_ack_out(acko));
    msh_peer msh_peer_inst (.clk(clk), .srst(srst), .req(rqo),
        .slow(slow), .ack(acki));
    task chk(input logic g, input logic e);
        compares++;
        if (g !== e) begin
            miscompares++;
            $display("[FAIL] %0t got %b expected %b", $time, g, e);
        end
    endtask
    task final_report;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task sync(input logic [1:0] k, input logic [4:0] o, input logic ir);
        logic e;
        e = (k == msh_pkg::INSN_FSYNC) ||
            (k == msh_pkg::INSN_BAR && o <= msh_pkg::ORD_SYNC_MAX);
        sbe = 0; kind = k; ord = o; iv = 1; s = 0;
        @(negedge clk); iv = 0; kind = msh_pkg::INSN_NONE;
        repeat (3) @(negedge clk);
        chk(rqo, 1'b0);
        chk(stall, e);
        chk(flush, e);
        sbe = 1; slow = slow | ir;
        for (i = 0; i < 10 && rqo !== 1'b1; i++) @(negedge clk);
        chk(rqo, e);
        irq = ir;
        for (i = 0; i < 20 && e && !s; i++) begin
            @(negedge clk);
            s = s | (ir ? abrt : done);
        end
        chk(s, e);
        chk(rqo, 1'b0);
        @(negedge clk); irq = 0;
        chk(rqo, 1'b0);
        $display("sync test kind %0d field %0d ended", k, o);
    endtask
    task resp(input logic [3:0] n, input logic wd);
        // raise only after a low spell
        cnt = n; rqi = 1;
        repeat (3) @(negedge clk);
        chk(acko, n == 0);
        chk(drn, n != 0);
        rqi = !wd;
        while (cnt != 0) begin
            pop = 1; @(negedge clk); cnt = cnt - 4'h1;
        end
        pop = 0;
        for (i = 0; i < 5 && acko !== !wd; i++) @(negedge clk);
        chk(acko, !wd);
        chk(drn, 1'b0);
        rqi = 0; @(negedge clk);
        chk(acko, 1'b0);
        $display("respond test count %0d ended", n);
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            miscompares++;
            final_report;
        end
    end
    initial begin
        repeat (8) @(negedge clk); srst = 0;
        sync(msh_pkg::INSN_BAR, 5'h01, 0);
        sync(msh_pkg::INSN_BAR, 5'h02, 0);
        sync(msh_pkg::INSN_FSYNC, 5'h00, 1);
        sync(msh_pkg::INSN_FSYNC, 5'h00, 0);
        resp(4'h0, 0);
        resp(4'h3, 1);
        repeat (8) begin
            slow = 1'($random(seed) & 1);
            sync(2'h1 + 2'($random(seed) & 1), 5'($random(seed) & 3), 0);
            resp(4'($random(seed) & 7), 0);
        end
        final_report;
    end
endmodule

// >>> msh_core.sv
`timescale 1ns/10ps

module msh_core #(
    parameter int SNQ_CNT_W = msh_pkg::SNQ_CNT_W
) (
    // Clock and reset
    input  wire logic                       clk,
    input  wire logic                       srst,
    // Instruction issue
    input  wire logic                       insn_valid,
    input  wire logic [1:0]                 insn_kind,
    input  wire logic [msh_pkg::ORD_W-1:0]  barrier_ordering_field,
    input  wire logic                       irq_pending,
    // Internal buffers
    input  wire logic                       store_bufs_empty,
    input  wire logic [SNQ_CNT_W-1:0]       snoop_q_count,
    input  wire logic                       snoop_pop,
    // Pipeline controls
    output logic                            operand_stall,
    output logic                            store_flush,
    output logic                            sync_done,
    output logic                            sync_abort,
    output logic                            snoop_drain,
    // Sync handshake pins
    output logic                            sync_req_out,
    input  wire logic                       sync_ack_in,
    input  wire logic                       sync_req_in,
    output logic                            sync_ack_out
);

    // ----------------------------------------------------------------
    // Initiator side
    // ----------------------------------------------------------------
    msh_pkg::msh_init_st_t ist;
    logic                  sync_insn;

    always_comb begin
        sync_insn = insn_valid &&
            ((insn_kind == msh_pkg::INSN_FSYNC) ||
             ((insn_kind == msh_pkg::INSN_BAR) &&
              (barrier_ordering_field <= msh_pkg::ORD_SYNC_MAX)));
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            ist           <= msh_pkg::MSH_I_IDLE;
            sync_req_out  <= 1'b0;
            operand_stall <= 1'b0;
            store_flush   <= 1'b0;
            sync_done     <= 1'b0;
            sync_abort    <= 1'b0;
        end else begin
            sync_done  <= 1'b0;
            sync_abort <= 1'b0;
            case (ist)
                msh_pkg::MSH_I_IDLE: begin
                    if (sync_insn) begin
                        operand_stall <= 1'b1;
                        store_flush   <= 1'b1;
                        ist           <= msh_pkg::MSH_I_DRAIN;
                    end
                end
                msh_pkg::MSH_I_DRAIN: begin
                    if (irq_pending) begin
                        operand_stall <= 1'b0;
                        store_flush   <= 1'b0;
                        sync_abort    <= 1'b1;
                        ist           <= msh_pkg::MSH_I_IDLE;
                    end else if (store_bufs_empty && !sync_ack_in) begin
                        store_flush  <= 1'b0;
                        sync_req_out <= 1'b1;
                        ist          <= msh_pkg::MSH_I_REQ;
                    end
                end
                msh_pkg::MSH_I_REQ: begin
                    // Same-clock partner, read directly to finish next cycle
                    if (sync_ack_in) begin
                        sync_req_out  <= 1'b0;
                        sync_done     <= 1'b1;
                        operand_stall <= 1'b0;
                        ist           <= msh_pkg::MSH_I_GAP;
                    end else if (irq_pending) begin
                        sync_req_out  <= 1'b0;
                        sync_abort    <= 1'b1;
                        operand_stall <= 1'b0;
                        ist           <= msh_pkg::MSH_I_GAP;
                    end
                end
                msh_pkg::MSH_I_GAP: begin
                    ist <= msh_pkg::MSH_I_IDLE;
                end
                default: begin
                    ist           <= msh_pkg::MSH_I_IDLE;
                    sync_req_out  <= 1'b0;
                    operand_stall <= 1'b0;
                    store_flush   <= 1'b0;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Responder side
    // ----------------------------------------------------------------
    msh_pkg::msh_resp_st_t rsp_st;
    logic [SNQ_CNT_W-1:0]  snoop_left;

    always_ff @(posedge clk) begin
        if (srst) begin
            rsp_st       <= msh_pkg::MSH_R_IDLE;
            snoop_left   <= '0;
            snoop_drain  <= 1'b0;
            sync_ack_out <= 1'b0;
        end else begin
            case (rsp_st)
                msh_pkg::MSH_R_IDLE: begin
                    // Idle is re-entered with the request seen low, except through reset or from an illegal state through the default branch
                    if (sync_req_in) begin
                        snoop_left <= snoop_q_count;
                        if (snoop_q_count == '0) begin
                            sync_ack_out <= 1'b1;
                            rsp_st       <= msh_pkg::MSH_R_ACK;
                        end else begin
                            snoop_drain <= 1'b1;
                            rsp_st      <= msh_pkg::MSH_R_DRAIN;
                        end
                    end
                end
                msh_pkg::MSH_R_DRAIN: begin
                    if (!sync_req_in) begin
                        // withdrawn, abandon drain
                        // Abandoning frees the snoop path soonest
                        snoop_drain <= 1'b0;
                        snoop_left  <= '0;
                        rsp_st      <= msh_pkg::MSH_R_IDLE;
                    end else if (snoop_pop) begin
                        snoop_left <= snoop_left - SNQ_CNT_W'(1);
                        if (snoop_left == SNQ_CNT_W'(1)) begin
                            snoop_drain  <= 1'b0;
                            sync_ack_out <= 1'b1;
                            rsp_st       <= msh_pkg::MSH_R_ACK;
                        end
                    end
                end
                msh_pkg::MSH_R_ACK: begin
                    if (!sync_req_in) begin
                        sync_ack_out <= 1'b0;
                        rsp_st       <= msh_pkg::MSH_R_IDLE;
                    end
                end
                default: begin
                    rsp_st       <= msh_pkg::MSH_R_IDLE;
                    snoop_left   <= '0;
                    snoop_drain  <= 1'b0;
                    sync_ack_out <= 1'b0;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Assertions and cover properties
    // ----------------------------------------------------------------
    // decode starts sync
    a_sync_decode: assert property (
        @(posedge clk) disable iff (srst)
        ist == msh_pkg::MSH_I_IDLE && insn_valid &&
        (insn_kind == msh_pkg::INSN_FSYNC ||
         (insn_kind == msh_pkg::INSN_BAR &&
          barrier_ordering_field <= msh_pkg::ORD_SYNC_MAX))
        |=> operand_stall && ist == msh_pkg::MSH_I_DRAIN)
        else $error("sync instruction did not start a sync");

    a_req_after_drain: assert property (
        @(posedge clk) disable iff (srst)
        $rose(sync_req_out) |-> $past(store_bufs_empty) && operand_stall)
        else $error("sync request raised before buffers drained");

    a_drain_on_req: assert property (
        @(posedge clk) disable iff (srst)
        rsp_st == msh_pkg::MSH_R_IDLE && sync_req_in &&
        snoop_q_count != '0 |=> snoop_drain)
        else $error("snoop drain did not start on request");

    a_ack_after_drain: assert property (
        @(posedge clk) disable iff (srst)
        sync_ack_out |-> snoop_left == '0 && !snoop_drain)
        else $error("acknowledge raised with snoops still owed");

    a_done_on_ack: assert property (
        @(posedge clk) disable iff (srst)
        sync_req_out && sync_ack_in |=> !sync_req_out && sync_done)
        else $error("sync did not complete the cycle after ack");

    a_ack_release: assert property (
        @(posedge clk) disable iff (srst)
        sync_ack_out && !sync_req_in |=> !sync_ack_out)
        else $error("acknowledge held after request dropped");

    a_abort_on_irq: assert property (
        @(posedge clk) disable iff (srst)
        sync_abort |-> $past(irq_pending) && !sync_req_out &&
        !operand_stall)
        else $error("abort without interrupt or request still up");

    a_ack_needs_req: assert property (
        @(posedge clk) disable iff (srst)
        $rose(sync_ack_out) |-> $past(sync_req_in))
        else $error("acknowledge raised without a request");

    a_quick_ack: assert property (
        @(posedge clk) disable iff (srst)
        rsp_st == msh_pkg::MSH_R_IDLE && sync_req_in &&
        snoop_q_count == '0 |=> sync_ack_out)
        else $error("empty snoop queue not acknowledged at once");

    a_req_gap: assert property (
        @(posedge clk) disable iff (srst)
        $fell(sync_req_out) |=> !sync_req_out)
        else $error("sync request re-raised without a low clock");

    c_sync_done: cover property (
        @(posedge clk) disable iff (srst) sync_done);

    c_sync_abort: cover property (
        @(posedge clk) disable iff (srst) sync_abort);

    c_quick_ack: cover property (
        @(posedge clk) disable iff (srst)
        $rose(sync_ack_out) && $past(rsp_st == msh_pkg::MSH_R_IDLE));

    c_drain_abandon: cover property (
        @(posedge clk) disable iff (srst)
        $fell(snoop_drain) && !sync_ack_out);
endmodule

// >>> msh_peer.sv
`timescale 1ns/10ps
// ------------------------------------------------------------
// Peer core seen through the coherency logic
// ------------------------------------------------------------
module msh_peer (
    // Clock and reset
    input  wire logic clk,
    input  wire logic srst,
    // Handshake
    input  wire logic req,
    input  wire logic slow,
    output logic      ack
);
    logic [2:0] n;
    // ack once queues done, may be instant
    // ack falls when request falls, so re-raise is needed
    always_ff @(posedge clk) begin
        if (srst || !req) begin
            n   <= 3'h0;
            ack <= 1'b0;
        end else if (!ack && n >= (slow ? 3'h6 : 3'h0)) begin
            ack <= 1'b1;
        end else begin
            n <= n + 3'h1;
        end
    end
endmodule

// >>> msh_pkg.sv
package msh_pkg;

    // ----------------------------------------------------------------
    // Instruction classes
    // ----------------------------------------------------------------
    localparam logic [1:0] INSN_NONE  = 2'h0;
    localparam logic [1:0] INSN_FSYNC = 2'h1;
    localparam logic [1:0] INSN_BAR   = 2'h2;

    localparam int         ORD_W        = 5;
    localparam logic [4:0] ORD_SYNC_MAX = 5'h01;

    localparam int         SNQ_CNT_W = 4;

    // ----------------------------------------------------------------
    // Initiator states
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        MSH_I_IDLE  = 3'b000,
        MSH_I_DRAIN = 3'b001,
        MSH_I_REQ   = 3'b010,
        MSH_I_GAP   = 3'b011
    } msh_init_st_t;

    // ----------------------------------------------------------------
    // Responder states
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        MSH_R_IDLE  = 2'b00,
        MSH_R_DRAIN = 2'b01,
        MSH_R_ACK   = 2'b10
    } msh_resp_st_t;

endpackage
